// >>> rtl/aphp_consts.svh
// What this block does
// [RULE_01] Low eight data pins are three-state, steered only by select and strobes.
// [RULE_02] Word mode: shared ninth pin is data bit 8, same strobes.
// [RULE_03] Byte mode: shared ninth pin becomes the upper byte select input.
// [RULE_04] Byte mode, select low: low byte travels on the low data lines.
// [RULE_05] Byte mode, select high: top four result bits on lines zero to three.
// [RULE_06] High byte read drives the channel identifier on lines four to six.
// [RULE_07] High byte write: host drives zeros on lines four to seven.
// [RULE_08] Word mode: lines nine to eleven carry the top bits, three-state.
// [RULE_09] Busy rises after conversion start falls and stays high throughout.
// [RULE_10] Busy falls only after the new result sits in the output register.
// [RULE_11] Sampling returns to track on the thirteenth master clock rising edge.
// [RULE_12] Conversion start falling edge sets hold and begins a conversion.
// [RULE_13] Read strobe low with select low puts the result on the bus.
// [RULE_14] Write strobe low with select low writes bus data to registers.
// [RULE_15] A conversion lasts thirteen master clock cycles; clock may be burst.
// [RULE_16] Byte mode host completes a word as a low then a high access.
`ifndef APHP_CONSTS_SVH
`define APHP_CONSTS_SVH
`define APHP_DATA_W 12
`define APHP_CHAN_W 3
`define APHP_CNT_W 4
`define APHP_CONV_EDGES 4'hd
`define APHP_PINS_W 6
`define APHP_PINS_INIT 6'h3e
`define APHP_BYTE_OE 12'h0ff
`define APHP_WORD_OE 12'hfff
`define APHP_NO_OE 12'h000
`define APHP_BIT8_POS 8
`endif

// >>> rtl/aphp_pkg.sv
`include "aphp_consts.svh"
package aphp_pkg;
    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic conversionStartN;
        logic wordByteSel;
        logic masterClockIn;
    } aphp_pins_type;

    typedef struct packed {
        logic [`APHP_CHAN_W-1:0] channel;
        logic [`APHP_DATA_W-1:0] value;
    } aphp_result_type;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_DONE
    } aphp_conv_state_type;
endpackage : aphp_pkg

// >>> rtl/aphp_sync.sv
`timescale 1ns/1ps
module aphp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] stable
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] stable_r;
    logic [WIDTH-1:0] stable_nxt;
    logic [WIDTH-1:0] differ;

    // A bit only moves once the second and third stages agree.
    assign differ = s2_r ^ s3_r;
    assign stable_nxt = (s2_r & ~differ) | (stable_r & differ);
    assign stable = stable_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            stable_r <= INIT;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stable_r <= stable_nxt;
        end
    end
endmodule : aphp_sync

// >>> rtl/aphp_host_port.sv
`timescale 1ns/1ps
`include "aphp_consts.svh"
module aphp_host_port
    import aphp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic conversionStartN,
    input wire logic wordByteSel,
    input wire logic masterClockIn,
    input wire logic [7:0] lowDataLinesIn,
    output logic [7:0] lowDataLinesOut,
    output logic [7:0] lowDataLinesOe,
    input wire logic bit8OrByteSelectPinIn,
    output logic bit8OrByteSelectPinOut,
    output logic bit8OrByteSelectPinOe,
    input wire logic [2:0] upperDataLinesIn,
    output logic [2:0] upperDataLinesOut,
    output logic [2:0] upperDataLinesOe,
    input wire aphp_result_type resultIn,
    output logic busy,
    output logic trackHold,
    output logic [`APHP_DATA_W-1:0] writeWord,
    output logic writeStrobe
);
    aphp_pins_type pinsRaw;
    aphp_pins_type pinsS;
    logic [`APHP_DATA_W-1:0] dataRaw;
    logic [`APHP_DATA_W-1:0] dataS;

    assign pinsRaw = '{csN, rdN, wrN, conversionStartN, wordByteSel,
                       masterClockIn};
    assign dataRaw = {upperDataLinesIn, bit8OrByteSelectPinIn,
                      lowDataLinesIn};

    aphp_sync #(.WIDTH(`APHP_PINS_W), .INIT(`APHP_PINS_INIT)) ctrlSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(pinsRaw),
        .stable(pinsS)
    );

    aphp_sync #(.WIDTH(`APHP_DATA_W), .INIT('0)) dataSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(dataRaw),
        .stable(dataS)
    );

    logic convPrev_r;
    logic mclkPrev_r;
    logic writePrev_r;
    aphp_conv_state_type state_r;
    aphp_conv_state_type state_nxt;
    logic [`APHP_CNT_W-1:0] edgeCnt_r;
    logic [`APHP_CNT_W-1:0] edgeCnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic hold_r;
    logic hold_nxt;
    aphp_result_type result_r;
    logic [`APHP_DATA_W-1:0] dataOut_r;
    logic [`APHP_DATA_W-1:0] dataOe_r;
    logic [`APHP_DATA_W-1:0] wrLatch_r;
    logic wrHigh_r;
    logic wrByte_r;
    logic [7:0] lowPending_r;
    logic [`APHP_DATA_W-1:0] writeWord_r;
    logic writeStrobe_r;

    logic readActive;
    logic writeActive;
    logic byteMode;
    logic upperSel;
    logic convStartFall;
    logic mclkRise;
    logic lastEdge;
    logic writeEnd;
    logic [7:0] highByte;
    logic [7:0] lowByte;
    logic [7:0] byteSel;
    logic [`APHP_DATA_W-1:0] readData_nxt;
    logic [`APHP_DATA_W-1:0] readOe_nxt;
    logic [`APHP_DATA_W-1:0] writeWord_nxt;
    logic writeCommit;

    assign readActive = !pinsS.csN && !pinsS.rdN;
    assign writeActive = !pinsS.csN && !pinsS.wrN;
    assign byteMode = !pinsS.wordByteSel;
    // [RULE_03] Upper byte select.
    assign upperSel = dataS[`APHP_BIT8_POS];
    // [RULE_12] Start edge detect.
    assign convStartFall = convPrev_r && !pinsS.conversionStartN;
    // The master clock may come in bursts, so only its rising edges count.
    assign mclkRise = !mclkPrev_r && pinsS.masterClockIn;
    assign lastEdge = mclkRise && (edgeCnt_r == (`APHP_CONV_EDGES - 4'h1));
    assign writeEnd = writePrev_r && !writeActive;

    // [RULE_06] Channel on high byte.
    assign highByte = {1'b0, result_r.channel, result_r.value[11:8]};
    // [RULE_04] Low byte placement.
    assign lowByte = result_r.value[7:0];
    // [RULE_05] Top bits low.
    assign byteSel = upperSel ? highByte : lowByte;
    // [RULE_08] Word mode full width.
    assign readData_nxt = byteMode ? {4'h0, byteSel} : result_r.value;
    // [RULE_01] Drive by strobes only.
    assign readOe_nxt = !readActive ? `APHP_NO_OE :
                        byteMode ? `APHP_BYTE_OE : `APHP_WORD_OE;

    // [RULE_16] Byte pair assembly.
    assign writeWord_nxt = !wrByte_r ? wrLatch_r :
                           {wrLatch_r[3:0], lowPending_r};
    // [RULE_14] Commit on strobe end.
    assign writeCommit = writeEnd && (!wrByte_r || wrHigh_r);

    // [RULE_15] Thirteen edge conversion.
    always_comb begin
        state_nxt = state_r;
        edgeCnt_nxt = edgeCnt_r;
        busy_nxt = busy_r;
        hold_nxt = hold_r;
        unique case (state_r)
            CONV_IDLE: begin
                // [RULE_09] Busy on start.
                if (convStartFall) begin
                    state_nxt = CONV_RUN;
                    edgeCnt_nxt = '0;
                    busy_nxt = 1'b1;
                    hold_nxt = 1'b1;
                end
            end
            CONV_RUN: begin
                if (mclkRise) begin
                    edgeCnt_nxt = edgeCnt_r + 4'h1;
                end
                // [RULE_11] Back to track.
                if (lastEdge) begin
                    state_nxt = CONV_DONE;
                    hold_nxt = 1'b0;
                end
            end
            CONV_DONE: begin
                // [RULE_10] Busy falls after latch.
                state_nxt = CONV_IDLE;
                busy_nxt = 1'b0;
            end
            // The fourth two-bit code is illegal and falls back to idle.
            default: begin
                state_nxt = CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= CONV_IDLE;
            edgeCnt_r <= '0;
            busy_r <= 1'b0;
            hold_r <= 1'b0;
            convPrev_r <= 1'b1;
            mclkPrev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            edgeCnt_r <= edgeCnt_nxt;
            busy_r <= busy_nxt;
            hold_r <= hold_nxt;
            convPrev_r <= pinsS.conversionStartN;
            mclkPrev_r <= pinsS.masterClockIn;
        end
    end

    // The result register loads on the last edge, one cycle before busy drops.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            result_r <= '0;
        end else if (state_r == CONV_RUN && lastEdge) begin
            result_r <= resultIn;
        end
    end

    // [RULE_13] Result onto bus.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dataOut_r <= '0;
            dataOe_r <= '0;
        end else begin
            dataOut_r <= readData_nxt;
            dataOe_r <= readOe_nxt;
        end
    end

    // Data is captured every cycle of the strobe so the last sample wins.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            writePrev_r <= 1'b0;
            wrLatch_r <= '0;
            wrHigh_r <= 1'b0;
            wrByte_r <= 1'b0;
        end else begin
            writePrev_r <= writeActive;
            if (writeActive) begin
                wrLatch_r <= dataS;
                wrHigh_r <= upperSel;
                wrByte_r <= byteMode;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lowPending_r <= '0;
            writeWord_r <= '0;
            writeStrobe_r <= 1'b0;
        end else begin
            writeStrobe_r <= writeCommit;
            if (writeEnd && wrByte_r && !wrHigh_r) begin
                lowPending_r <= wrLatch_r[7:0];
            end
            if (writeCommit) begin
                writeWord_r <= writeWord_nxt;
            end
        end
    end

    assign lowDataLinesOut = dataOut_r[7:0];
    assign lowDataLinesOe = dataOe_r[7:0];
    // [RULE_02] Bit 8 as data.
    assign bit8OrByteSelectPinOut = dataOut_r[8];
    assign bit8OrByteSelectPinOe = dataOe_r[8];
    assign upperDataLinesOut = dataOut_r[11:9];
    assign upperDataLinesOe = dataOe_r[11:9];
    assign busy = busy_r;
    assign trackHold = hold_r;
    assign writeWord = writeWord_r;
    assign writeStrobe = writeStrobe_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    busy_rise_a: assert property ( // [RULE_09]
        state_r == CONV_IDLE && convStartFall |=> busy_r && hold_r)
        else $error("busy not raised");
    busy_hold_a: assert property ( // [RULE_09]
        state_r == CONV_RUN |-> busy_r)
        else $error("busy low during conversion");
    busy_fall_a: assert property ( // [RULE_10]
        $fell(busy_r) |-> $past(state_r) == CONV_DONE && !hold_r)
        else $error("busy fell early");
    track_edge_a: assert property ( // [RULE_11]
        state_r == CONV_RUN && lastEdge |=> !hold_r && busy_r
        && result_r == $past(resultIn) ##1 !busy_r)
        else $error("track or result wrong");
    edge_count_a: assert property ( // [RULE_15]
        state_r == CONV_RUN |-> edgeCnt_r < `APHP_CONV_EDGES)
        else $error("edge count overrun");
    drive_gate_a: assert property ( // [RULE_01]
        dataOe_r != '0 |-> $past(readActive))
        else $error("bus driven without strobe");
    bit8_input_a: assert property ( // [RULE_03]
        byteMode |=> !dataOe_r[8] && dataOe_r[11:9] == 3'h0)
        else $error("bit 8 driven in byte mode");
    high_byte_a: assert property ( // [RULE_06]
        readActive && byteMode && upperSel
        |=> dataOut_r[6:4] == $past(result_r.channel)
        && dataOut_r[3:0] == $past(result_r.value[11:8]))
        else $error("high byte wrong");
    low_byte_a: assert property ( // [RULE_04]
        readActive && byteMode && !upperSel
        |=> dataOut_r[7:0] == $past(result_r.value[7:0]))
        else $error("low byte wrong");
    word_read_a: assert property ( // [RULE_08]
        readActive && !byteMode |=> dataOe_r == `APHP_WORD_OE
        && dataOut_r == $past(result_r.value))
        else $error("word read wrong");
    word_write_a: assert property ( // [RULE_14]
        writeEnd && !wrByte_r |=> writeStrobe_r
        && writeWord_r == $past(wrLatch_r))
        else $error("word write lost");
    pair_write_a: assert property ( // [RULE_16]
        writeEnd && wrByte_r && wrHigh_r |=> writeStrobe_r
        && writeWord_r == {$past(wrLatch_r[3:0]), $past(lowPending_r)})
        else $error("byte pair wrong");

    conv_done_c: cover property (
        state_r == CONV_RUN ##1 state_r == CONV_DONE ##1 !busy_r);
    word_read_c: cover property (readActive && !byteMode);
    high_read_c: cover property (readActive && byteMode && upperSel);
    pair_write_c: cover property (writeCommit && wrByte_r);
endmodule : aphp_host_port

// >>> tb/aphp_core_model.sv
`timescale 1ns/1ps
module aphp_core_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic run,
    output logic masterClockIn
);
    logic [2:0] phase_r;
    // Burst master clock.
    // The clock stands low between conversions, so no stray edge is counted.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= 3'h0;
            masterClockIn <= 1'b0;
        end else if (!run) begin
            phase_r <= 3'h0;
            masterClockIn <= 1'b0;
        end else begin
            phase_r <= phase_r + 3'h1;
            if (phase_r == 3'h7) begin
                masterClockIn <= ~masterClockIn;
            end
        end
    end
endmodule : aphp_core_model

// >>> tb/adc_parallel_host_port_test.sv
`timescale 1ns/1ps
module adc_parallel_host_port_test;
    import aphp_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic csN = 1'b1, rdN = 1'b1, wrN = 1'b1, startN = 1'b1, wordSel = 1'b1;
    logic hostEn = 1'b0;
    logic [11:0] hostVal = 12'h000;
    logic [11:0] pat = 12'h000;
    aphp_result_type res = '0;
    logic mck, bOut, bOe, bIn, busy, trackHold, writeStrobe, s, th;
    logic [7:0] lowOut, lowOe, lowIn;
    logic [2:0] upOut, upOe, upIn;
    logic [11:0] writeWord, v, o;
    int errors = 0, checks = 0, rises = 0, i;
    always #25 mclk = ~mclk;
    // Released lines show a pattern that changes every cycle.
    always @(negedge mclk) pat <= pat + 12'h3c5;
    assign lowIn = (lowOe & lowOut)
        | (~lowOe & (hostEn ? hostVal[7:0] : pat[7:0]));
    assign bIn = bOe ? bOut : ((hostEn | ~wordSel) ? hostVal[8] : pat[8]);
    assign upIn = (upOe & upOut)
        | (~upOe & (hostEn ? hostVal[11:9] : pat[11:9]));
    aphp_host_port uut (.mclk(mclk), .reset_n(reset_n), .csN(csN), .rdN(rdN),
        .wrN(wrN), .conversionStartN(startN), .wordByteSel(wordSel),
        .masterClockIn(mck), .lowDataLinesIn(lowIn), .lowDataLinesOut(lowOut),
        .lowDataLinesOe(lowOe), .bit8OrByteSelectPinIn(bIn),
        .bit8OrByteSelectPinOut(bOut), .bit8OrByteSelectPinOe(bOe),
        .upperDataLinesIn(upIn), .upperDataLinesOut(upOut),
        .upperDataLinesOe(upOe), .resultIn(res), .busy(busy),
        .trackHold(trackHold), .writeWord(writeWord),
        .writeStrobe(writeStrobe));
    aphp_core_model model (.mclk(mclk), .reset_n(reset_n), .run(busy),
        .masterClockIn(mck));
    always @(posedge mck) if (busy === 1'b1) rises <= rises + 1;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task rd(input logic hb, output logic [11:0] d, output logic [11:0] oe);
        @(negedge mclk);
        hostVal[8] = hb;
        @(negedge mclk);
        csN = 1'b0;
        rdN = 1'b0;
        repeat (8) @(negedge mclk);
        d = {upIn, bIn, lowIn};
        oe = {upOe, bOe, lowOe};
        rdN = 1'b1;
        csN = 1'b1;
        repeat (8) @(negedge mclk);
        check(16'({upOe, bOe, lowOe}), 16'h0000);
    endtask : rd
    task wr(input logic [11:0] d, output logic seen);
        @(negedge mclk);
        hostEn = 1'b1;
        hostVal = d;
        @(negedge mclk);
        csN = 1'b0;
        wrN = 1'b0;
        repeat (8) @(negedge mclk);
        wrN = 1'b1;
        csN = 1'b1;
        for (i = 0; i < 12 && writeStrobe !== 1'b1; i++) @(negedge mclk);
        seen = writeStrobe;
        hostEn = 1'b0;
        repeat (6) @(negedge mclk);
    endtask : wr
    task print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check(16'({upOe, bOe, lowOe, busy, trackHold}), 16'h0000);
        res = {3'h5, 12'habc};
        startN = 1'b0;
        repeat (3) @(negedge mclk);
        startN = 1'b1;
        for (i = 0; i < 40 && busy !== 1'b1; i++) @(negedge mclk);
        check(16'({busy, trackHold}), 16'h0003);
        repeat (20) @(negedge mclk);
        startN = 1'b0;
        repeat (6) @(negedge mclk);
        startN = 1'b1;
        th = 1'b1;
        for (i = 0; i < 400 && busy === 1'b1; i++) begin
            th = trackHold;
            @(negedge mclk);
        end
        check(16'({busy, th}), 16'h0000);
        check(16'(rises), 16'h000d);
        res = {3'h2, 12'h123};
        repeat (20) @(negedge mclk);
        check(16'(busy), 16'h0000);
        rd(1'b0, v, o);
        check(16'(v), 16'h0abc);
        check(16'(o), 16'h0fff);
        wordSel = 1'b0;
        rd(1'b0, v, o);
        check(16'(v[7:0]), 16'h00bc);
        check(16'(o), 16'h00ff);
        rd(1'b1, v, o);
        check(16'(v[7:0]), 16'h005a);
        check(16'(o), 16'h00ff);
        wordSel = 1'b1;
        wr(12'h5a3, s);
        check(16'({s, writeWord}), 16'h15a3);
        wordSel = 1'b0;
        wr(12'h03c, s);
        check(16'(s), 16'h0000);
        wr(12'h10e, s);
        check(16'({s, writeWord}), 16'h1e3c);
        print_verdict();
    end
endmodule : adc_parallel_host_port_test
